/* File: inc/gpc_pkg.sv */
// Shared constants for the GPIO/PWM command port
package gpc_pkg;

  localparam int NPIN = 5;
  localparam int ADDR_W = 8;

  // Command packet fields
  localparam logic [7:0] CMD_SET_PIN = 8'h22;
  localparam logic [7:0] ACK_FLAG    = 8'h40;
  localparam logic [7:0] ERR_FLAG    = 8'hC0;
  localparam logic [7:0] LEN_VALUE   = 8'h02;
  localparam logic [7:0] LEN_CONFIG  = 8'h03;
  localparam logic [7:0] ACK_LEN     = 8'h00;
  localparam logic [7:0] STATE_HIGH  = 8'h64;
  localparam logic [7:0] LAST_PIN    = 8'h04;
  localparam logic [7:0] FDB_MASK    = 8'h0F;
  localparam int         FUNC_BIT    = 3;

  // Drive mode codes
  localparam logic [2:0] DM_FAST_UP_PULL_DN = 3'h0;
  localparam logic [2:0] DM_FAST_BOTH       = 3'h1;
  localparam logic [2:0] DM_HIZ             = 3'h2;
  localparam logic [2:0] DM_PULL_UP_FAST_DN = 3'h3;
  localparam logic [2:0] DM_SLOW_UP_HIZ     = 3'h4;
  localparam logic [2:0] DM_SLOW_BOTH       = 3'h5;
  localparam logic [2:0] DM_RESERVED        = 3'h6;
  localparam logic [2:0] DM_HIZ_SLOW_DN     = 3'h7;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_HDR   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ARGS  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACK   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_QUERY = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_BOOT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h14;

  // Field positions
  localparam int BOOT_STORE_BIT = 0;
  localparam int BOOT_LOAD_BIT  = 1;

  // Reset defaults, pin 4 in the top byte
  localparam logic [NPIN*8-1:0] DEF_STATE = 40'h00_00_00_00_00;
  localparam logic [NPIN*8-1:0] DEF_FDB   = 40'h03_02_02_03_02;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int PWM_HZ       = 100;
  localparam int PWM_STEPS    = 100;
  localparam int SAMPLE_HZ    = 32;
  localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int SAMPLE_CYC   = CLK_HZ / SAMPLE_HZ;

  typedef enum logic [2:0] {
    SEL_HDR, SEL_ARGS, SEL_ACK, SEL_QUERY, SEL_BOOT, SEL_LEVEL, SEL_NONE
  } gpc_sel_type;

endpackage : gpc_pkg

/* File: rtl/gpc_pwm_base.sv */
// Shared PWM timebase: step counter over one period
`timescale 1ns/10ps
module gpc_pwm_base #(
  parameter int STEP_CYC = gpc_pkg::PWM_STEP_CYC,
  parameter int STEPS    = gpc_pkg::PWM_STEPS
) (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Step within the period
  output logic [6:0]      step
);
  localparam int PW = $clog2(STEP_CYC);

  logic [PW-1:0] pre_cnt;
  logic          pre_end;

  assign pre_end = (pre_cnt == PW'(STEP_CYC - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt <= '0;
    end else if (ce) begin
      pre_cnt <= pre_end ? '0 : pre_cnt + PW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step <= '0;
    end else if (ce && pre_end) begin
      step <= (step == 7'(STEPS - 1)) ? '0 : step + 7'h01;
    end
  end
endmodule : gpc_pwm_base

/* File: rtl/gpc_sampler.sv */
// Periodic pin sampler with sticky edge flags
`timescale 1ns/10ps
module gpc_sampler #(
  parameter int NPIN     = gpc_pkg::NPIN,
  parameter int TICK_CYC = gpc_pkg::SAMPLE_CYC
) (
  // Clock and control
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            ce,
  // Pins and flag clear
  input  wire logic [NPIN-1:0] pin_raw,
  input  wire logic [NPIN-1:0] clr,
  // Sampled state
  output logic      [NPIN-1:0] level,
  output logic      [NPIN-1:0] rise,
  output logic      [NPIN-1:0] fall
);
  localparam int CW = $clog2(TICK_CYC);

  logic [NPIN-1:0] sync_a;
  logic [NPIN-1:0] sync_b;
  logic [CW-1:0]   tick_cnt;
  logic            tick;
  logic            primed;
  logic [NPIN-1:0] set_r;
  logic [NPIN-1:0] set_f;

  assign tick  = (tick_cnt == CW'(TICK_CYC - 1));
  assign set_r = (tick && primed) ? (sync_b & ~level) : '0;
  assign set_f = (tick && primed) ? (~sync_b & level) : '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (ce) begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= '0;
    end else if (ce) begin
      tick_cnt <= tick ? '0 : tick_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level  <= '0;
      primed <= 1'b0;
    end else if (ce && tick) begin
      level  <= sync_b;
      primed <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rise <= '0;
      fall <= '0;
    end else if (ce) begin
      rise <= (rise & ~clr) | set_r;
      fall <= (fall & ~clr) | set_f;
    end
  end
endmodule : gpc_sampler

/* File: rtl/gpc_top.sv */
// GPIO/PWM command port with AXI4-Lite register access
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module gpc_top #(
  parameter int PWM_STEP_CYC = gpc_pkg::PWM_STEP_CYC,
  parameter int SAMPLE_CYC   = gpc_pkg::SAMPLE_CYC,
  parameter int NPIN         = gpc_pkg::NPIN
) (
  // Clock, reset, enable
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      ce,
  // AXI4-Lite write address
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [gpc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // AXI4-Lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [gpc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  // AXI4-Lite read data
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  // Default-role levels from power and one-wire logic
  input  wire logic [NPIN-1:0]           alt_level,
  // Pins
  input  wire logic [NPIN-1:0]           gpio_in,
  output logic      [NPIN-1:0]           gpio_out,
  output logic      [NPIN-1:0]           gpio_oe_n,
  output logic      [NPIN-1:0]           gpio_pull_up,
  output logic      [NPIN-1:0]           gpio_pull_dn,
  output logic      [NPIN-1:0]           gpio_slow,
  // Sampled levels for default-role logic
  output logic      [NPIN-1:0]           pin_level
);

  // Register select from a byte address
  function automatic gpc_pkg::gpc_sel_type reg_sel(input logic [gpc_pkg::ADDR_W-1:0] a);
    case (a)
      gpc_pkg::OFF_HDR:   reg_sel = gpc_pkg::SEL_HDR;
      gpc_pkg::OFF_ARGS:  reg_sel = gpc_pkg::SEL_ARGS;
      gpc_pkg::OFF_ACK:   reg_sel = gpc_pkg::SEL_ACK;
      gpc_pkg::OFF_QUERY: reg_sel = gpc_pkg::SEL_QUERY;
      gpc_pkg::OFF_BOOT:  reg_sel = gpc_pkg::SEL_BOOT;
      gpc_pkg::OFF_LEVEL: reg_sel = gpc_pkg::SEL_LEVEL;
      default:            reg_sel = gpc_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction : merge

  // Drive decode: {drive, value, pull_up, pull_dn, slow}
  function automatic logic [4:0] drive(input logic [2:0] mode, input logic lvl);
    case (mode)
      gpc_pkg::DM_FAST_UP_PULL_DN: drive = lvl ? 5'h18 : 5'h02;
      gpc_pkg::DM_FAST_BOTH:       drive = lvl ? 5'h18 : 5'h10;
      gpc_pkg::DM_HIZ:             drive = 5'h00;
      gpc_pkg::DM_PULL_UP_FAST_DN: drive = lvl ? 5'h04 : 5'h10;
      gpc_pkg::DM_SLOW_UP_HIZ:     drive = lvl ? 5'h19 : 5'h00;
      gpc_pkg::DM_SLOW_BOTH:       drive = lvl ? 5'h19 : 5'h11;
      gpc_pkg::DM_HIZ_SLOW_DN:     drive = lvl ? 5'h00 : 5'h11;
      default:                     drive = 5'h00;
    endcase
  endfunction : drive

  logic                       aw_held;
  logic [gpc_pkg::ADDR_W-1:0] aw_addr;
  logic                       w_held;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       do_write;
  gpc_pkg::gpc_sel_type       wr_sel;
  gpc_pkg::gpc_sel_type       rd_sel;
  logic                       rd_take;

  logic [15:0]                hdr;
  logic [23:0]                args;
  logic [31:0]                next_hdr;
  logic [31:0]                next_args;
  logic [7:0]                 ack_type;
  logic                       ack_valid;
  logic [31:0]                query;
  logic [NPIN-1:0]            clr;

  logic [7:0]                 pin_state [NPIN];
  logic [7:0]                 pin_fdb   [NPIN];
  logic [7:0]                 boot_state [NPIN];
  logic [7:0]                 boot_fdb   [NPIN];

  logic [6:0]                 step;
  logic [NPIN-1:0]            s_level;
  logic [NPIN-1:0]            s_rise;
  logic [NPIN-1:0]            s_fall;

  logic                       wr_hdr;
  logic                       wr_query;
  logic                       wr_boot;
  logic                       cmd_ok;
  logic [7:0]                 cmd_type;
  logic [7:0]                 cmd_len;
  logic [7:0]                 cmd_pin;
  logic [7:0]                 cmd_state;
  logic [7:0]                 q_pin;

  assign do_write  = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel    = reg_sel(aw_addr);
  assign rd_sel    = reg_sel(s_axi_araddr);
  assign rd_take   = s_axi_arvalid && s_axi_arready;
  assign wr_hdr    = do_write && (wr_sel == gpc_pkg::SEL_HDR);
  assign wr_query  = do_write && (wr_sel == gpc_pkg::SEL_QUERY);
  assign wr_boot   = do_write && (wr_sel == gpc_pkg::SEL_BOOT);
  assign next_hdr  = merge({16'h0000, hdr}, w_data, w_strb);
  assign next_args = merge({8'h00, args}, w_data, w_strb);
  assign cmd_type  = next_hdr[7:0];
  assign cmd_len   = next_hdr[15:8];
  assign cmd_pin   = args[7:0];
  assign cmd_state = args[15:8];
  assign q_pin     = w_data[7:0];

  assign cmd_ok = (cmd_type == gpc_pkg::CMD_SET_PIN)
               && (cmd_len == gpc_pkg::LEN_VALUE || cmd_len == gpc_pkg::LEN_CONFIG)
               && (cmd_pin <= gpc_pkg::LAST_PIN)
               && (cmd_state <= gpc_pkg::STATE_HIGH);

  // Write address and data, either order
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b1;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b1;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == gpc_pkg::SEL_NONE) ? gpc_pkg::RESP_SLVERR
                                                       : gpc_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Packet header and argument holding
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hdr  <= '0;
      args <= '0;
    end else if (ce && do_write) begin
      if (wr_sel == gpc_pkg::SEL_HDR) begin
        hdr <= next_hdr[15:0];
      end
      if (wr_sel == gpc_pkg::SEL_ARGS) begin
        args <= next_args[23:0];
      end
    end
  end

  // acknowledge, new ack beats read clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_type  <= '0;
      ack_valid <= 1'b0;
    end else if (ce) begin
      if (wr_hdr) begin
        ack_type  <= cmd_ok ? (gpc_pkg::ACK_FLAG | cmd_type) : (gpc_pkg::ERR_FLAG | cmd_type);
        ack_valid <= 1'b1;
      end else if (rd_take && rd_sel == gpc_pkg::SEL_ACK) begin
        ack_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NPIN; i++) begin
        pin_state[i]  <= gpc_pkg::DEF_STATE[i*8 +: 8];
        pin_fdb[i]    <= gpc_pkg::DEF_FDB[i*8 +: 8];
        boot_state[i] <= gpc_pkg::DEF_STATE[i*8 +: 8];
        boot_fdb[i]   <= gpc_pkg::DEF_FDB[i*8 +: 8];
      end
    end else if (ce) begin
      if (wr_hdr && cmd_ok) begin
        pin_state[cmd_pin[2:0]] <= cmd_state;
        if (cmd_len == gpc_pkg::LEN_CONFIG) begin
          pin_fdb[cmd_pin[2:0]] <= args[23:16] & gpc_pkg::FDB_MASK;
        end
      end else if (wr_boot && w_data[gpc_pkg::BOOT_LOAD_BIT]) begin
        for (int i = 0; i < NPIN; i++) begin
          pin_state[i] <= boot_state[i];
          pin_fdb[i]   <= boot_fdb[i];
        end
      end
      if (wr_boot && w_data[gpc_pkg::BOOT_STORE_BIT]) begin
        for (int i = 0; i < NPIN; i++) begin
          boot_state[i] <= pin_state[i];
          boot_fdb[i]   <= pin_fdb[i];
        end
      end
    end
  end

  always_comb begin
    clr = '0;
    if (wr_query && q_pin <= gpc_pkg::LAST_PIN) begin
      clr[q_pin[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      query <= '0;
    end else if (ce && wr_query) begin
      if (q_pin <= gpc_pkg::LAST_PIN) begin
        query <= {pin_fdb[q_pin[2:0]], pin_state[q_pin[2:0]], 5'h00,
                  s_rise[q_pin[2:0]], s_fall[q_pin[2:0]], s_level[q_pin[2:0]], q_pin};
      end else begin
        query <= {24'h000000, q_pin};
      end
    end
  end

  // Read channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= gpc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= gpc_pkg::RESP_OKAY;
        case (rd_sel)
          gpc_pkg::SEL_HDR:   s_axi_rdata <= {16'h0000, hdr};
          gpc_pkg::SEL_ARGS:  s_axi_rdata <= {8'h00, args};
          gpc_pkg::SEL_ACK:   s_axi_rdata <= {15'h0000, ack_valid, gpc_pkg::ACK_LEN, ack_type};
          gpc_pkg::SEL_QUERY: s_axi_rdata <= query;
          gpc_pkg::SEL_BOOT:  s_axi_rdata <= '0;
          gpc_pkg::SEL_LEVEL: s_axi_rdata <= 32'(s_level);
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= gpc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  gpc_pwm_base #(
    .STEP_CYC (PWM_STEP_CYC),
    .STEPS    (gpc_pkg::PWM_STEPS)
  ) u_pwm (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .step   (step)
  );

  gpc_sampler #(
    .NPIN     (NPIN),
    .TICK_CYC (SAMPLE_CYC)
  ) u_smp (
    .clk     (clk),
    .resetn  (resetn),
    .ce      (ce),
    .pin_raw (gpio_in),
    .clr     (clr),
    .level   (s_level),
    .rise    (s_rise),
    .fall    (s_fall)
  );

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    logic       lvl;
    logic [4:0] drv;

    assign lvl = pin_fdb[g][gpc_pkg::FUNC_BIT] ? ({1'b0, step} < pin_state[g]) : alt_level[g];
    assign drv = drive(pin_fdb[g][2:0], lvl);

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        gpio_out[g]     <= 1'b0;
        gpio_oe_n[g]    <= 1'b1;
        gpio_pull_up[g] <= 1'b0;
        gpio_pull_dn[g] <= 1'b0;
        gpio_slow[g]    <= 1'b0;
      end else if (ce) begin
        gpio_oe_n[g]    <= ~drv[4];
        gpio_out[g]     <= drv[3];
        gpio_pull_up[g] <= drv[2];
        gpio_pull_dn[g] <= drv[1];
        gpio_slow[g]    <= drv[0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_level <= '0;
    end else if (ce) begin
      pin_level <= s_level;
    end
  end

endmodule : gpc_top

/* File: sim/gpc_top_properties.sv */
// Bus, drive and sampling assertions for gpc_top
`timescale 1ns/10ps
module gpc_top_properties #(
  parameter int SAMPLE_CYC = 16
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Write channels
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins
  input wire logic [4:0] gpio_oe_n,
  input wire logic [4:0] gpio_pull_up,
  input wire logic [4:0] gpio_pull_dn,
  input wire logic [4:0] pin_level
);
  logic [31:0] gap;
  logic [4:0]  lvl_q;
  logic        armed;
  logic        chg;
  assign chg = pin_level != lvl_q;
  // Cycles between sampled level changes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap <= 32'h0;
      lvl_q <= 5'h00;
      armed <= 1'b0;
    end else begin
      lvl_q <= pin_level;
      gap <= chg ? 32'h1 : gap + 32'h1;
      armed <= armed | chg;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_drive_no_pull; (~gpio_oe_n & (gpio_pull_up | gpio_pull_dn)) == 5'h00; endproperty
  property p_pull_excl; (gpio_pull_up & gpio_pull_dn) == 5'h00; endproperty
  property p_sample_gap; chg && armed |-> (gap % SAMPLE_CYC) == 0; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
  a_drive_no_pull: assert property (p_drive_no_pull) else $error("pull while driving");
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  a_sample_gap: assert property (p_sample_gap) else $error("sample off tick");
endmodule : gpc_top_properties

bind gpc_top gpc_top_properties #(.SAMPLE_CYC(SAMPLE_CYC)) u_gpc_top_properties (.clk, .resetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .gpio_oe_n, .gpio_pull_up, .gpio_pull_dn, .pin_level);

/* File: sim/gpc_pin_load.sv */
// External load on the five pins: wire level from all drivers
`timescale 1ns/10ps
module gpc_pin_load (
  // Clock
  input wire logic       clk,
  // Device side
  input wire logic [4:0] gpio_out,
  input wire logic [4:0] gpio_oe_n,
  input wire logic [4:0] gpio_pull_up,
  input wire logic [4:0] gpio_pull_dn,
  // External driver
  input wire logic [4:0] ext_en,
  input wire logic [4:0] ext_val,
  // Resolved level
  output logic     [4:0] gpio_in
);
  initial gpio_in = 5'h00;
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (!gpio_oe_n[i]) gpio_in[i] <= gpio_out[i];
      else if (ext_en[i]) gpio_in[i] <= ext_val[i];
      else if (gpio_pull_up[i] || gpio_pull_dn[i]) gpio_in[i] <= gpio_pull_up[i];
      else gpio_in[i] <= ~gpio_in[i];
    end
  end
endmodule : gpc_pin_load

/* File: sim/tb_top.sv */
// Self-checking bench for the GPIO/PWM command port
`timescale 1ns/10ps
module tb_top;
  localparam int STEP = 4;
  localparam int SAMP = 16;
  logic        clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, d, ty, ix, sv, fb, bs, bf;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, seed;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [4:0]  alt_level, gpio_in, gpio_out, gpio_oe_n, gpio_pull_up, gpio_pull_dn, e, mk;
  logic [4:0]  gpio_slow, pin_level, ext_en, ext_val;
  logic [4:0][7:0] st, fd;
  int          n_errors, tests_run, cnt;

  gpc_top #(.PWM_STEP_CYC(STEP), .SAMPLE_CYC(SAMP)) u_gpc_top (.clk, .resetn, .ce(1'b1),
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .alt_level, .gpio_in, .gpio_out, .gpio_oe_n,
    .gpio_pull_up, .gpio_pull_dn, .gpio_slow, .pin_level);
  gpc_pin_load u_gpc_pin_load (.clk, .gpio_out, .gpio_oe_n, .gpio_pull_up, .gpio_pull_dn,
    .ext_en, .ext_val, .gpio_in);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr

  // Expected {oe_n, out, pull_up, pull_dn, slow}
  function automatic logic [4:0] exp_drv(input logic [2:0] m, input logic v);
    case (m)
      3'h0: exp_drv = v ? 5'h08 : 5'h12;
      3'h1: exp_drv = {1'b0, v, 3'h0};
      3'h3: exp_drv = v ? 5'h14 : 5'h00;
      3'h4: exp_drv = v ? 5'h09 : 5'h10;
      3'h5: exp_drv = {1'b0, v, 3'h1};
      3'h7: exp_drv = v ? 5'h10 : 5'h01;
      default: exp_drv = 5'h10;
    endcase
  endfunction : exp_drv

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    tests_run++;
    if (g !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk

  task automatic final_report;
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    bit ad, wd;
    @(posedge clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) ad = 1'b1;
      if (s_axi_wready === 1'b1) wd = 1'b1;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic cmd(input logic [7:0] t, ln, x, s, f);
    logic ok;
    ok = t == gpc_pkg::CMD_SET_PIN && ln inside {gpc_pkg::LEN_VALUE, gpc_pkg::LEN_CONFIG} &&
         x <= gpc_pkg::LAST_PIN && s <= gpc_pkg::STATE_HIGH;
    wr(gpc_pkg::OFF_ARGS, {8'h00, f, s, x});
    wr(gpc_pkg::OFF_HDR, {16'h0000, ln, t});
    rd(gpc_pkg::OFF_ACK);
    chk("ack", {1'b1, 8'h00, (ok ? gpc_pkg::ACK_FLAG : gpc_pkg::ERR_FLAG) | t}, rv[16:0]);
    if (ok) st[x] = s;
    if (ok && ln == gpc_pkg::LEN_CONFIG) fd[x] = f & gpc_pkg::FDB_MASK;
  endtask : cmd

  task automatic qchk(input logic [7:0] x);
    wr(gpc_pkg::OFF_QUERY, {24'h0, x});
    rd(gpc_pkg::OFF_QUERY);
    if (x <= gpc_pkg::LAST_PIN) chk("query", {fd[x], st[x], 8'h00, x}, rv & 32'hFFFF00FF);
    else chk("query_bad", {24'h0, x}, rv);
  endtask : qchk

  initial begin
    #600000;
    n_errors++;
    final_report;
  end

  initial begin
    n_errors = 0;
    tests_run = 0;
    seed = 32'h0476905E;
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {alt_level, ext_en, ext_val} = 15'h0;
    {st, fd} = {gpc_pkg::DEF_STATE, gpc_pkg::DEF_FDB};
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) qchk(i[7:0]);
    for (int m = 0; m < 8; m++) begin
      for (int v = 0; v < 2; v++) begin
        if (m != 6) begin
          cmd(gpc_pkg::CMD_SET_PIN, gpc_pkg::LEN_CONFIG, 8'h00, v ? 8'h64 : 8'h00, {5'h01, m[2:0]});
          repeat (3) @(posedge clk);
          e = exp_drv(m[2:0], v[0]);
          mk = e[4] ? 5'h16 : 5'h1F;
          chk("drive", e & mk, {gpio_oe_n[0], gpio_out[0], gpio_pull_up[0], gpio_pull_dn[0],
              gpio_slow[0]} & mk);
        end
      end
    end
    seed = lfsr(seed);
    d = 8'h01 + seed[7:0] % 8'h63;
    cmd(gpc_pkg::CMD_SET_PIN, gpc_pkg::LEN_CONFIG, 8'h00, d, 8'h09);
    repeat (3) @(posedge clk);
    cnt = 0;
    repeat (100 * STEP) begin
      @(posedge clk);
      if (gpio_out[0] === 1'b1) cnt++;
    end
    chk("pwm_high", d * STEP, cnt);
    cmd(gpc_pkg::CMD_SET_PIN, gpc_pkg::LEN_CONFIG, 8'h02, 8'h64, 8'h01);
    for (int v = 0; v < 2; v++) begin
      alt_level <= v ? 5'h04 : 5'h1B;
      repeat (4) @(posedge clk);
      chk("alt", {1'b0, v[0]}, {gpio_oe_n[2], gpio_out[2]});
    end
    ext_en <= 5'h02;
    cmd(gpc_pkg::CMD_SET_PIN, gpc_pkg::LEN_CONFIG, 8'h01, 8'h00, 8'h0A);
    repeat (4 * SAMP) @(posedge clk);
    qchk(8'h01);
    ext_val <= 5'h02;
    repeat (3 * SAMP) @(posedge clk);
    rd(gpc_pkg::OFF_LEVEL);
    chk("level_hi", 1'b1, rv[1]);
    ext_val <= 5'h00;
    repeat (3 * SAMP) @(posedge clk);
    qchk(8'h01);
    chk("edges", 3'h6, rv[10:8]);
    qchk(8'h01);
    chk("edges_clr", 3'h0, rv[10:8]);
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      ty = seed[2:0] == 3'h0 ? 8'h21 : gpc_pkg::CMD_SET_PIN;
      ix = {5'h00, seed[10:8]} % 8'h06;
      sv = seed[23:16] % 8'h66;
      fb = {4'h0, seed[27:24]};
      if (fb[2:0] == gpc_pkg::DM_RESERVED) fb[2:0] = gpc_pkg::DM_SLOW_BOTH;
      cmd(ty, seed[31] ? gpc_pkg::LEN_CONFIG : gpc_pkg::LEN_VALUE, ix, sv, fb);
      qchk(ix);
    end
    rd(gpc_pkg::OFF_ACK);
    chk("ack_clr", 1'b0, rv[16]);
    wr(gpc_pkg::OFF_BOOT, 32'h1);
    {bs, bf} = {st[0], fd[0]};
    cmd(gpc_pkg::CMD_SET_PIN, gpc_pkg::LEN_CONFIG, 8'h00, 8'h32, 8'h0D);
    wr(gpc_pkg::OFF_BOOT, 32'h2);
    {st[0], fd[0]} = {bs, bf};
    qchk(8'h00);
    wr(8'h18, 32'h000000FF);
    chk("bresp", gpc_pkg::RESP_SLVERR, rs);
    rd(8'h18);
    chk("rresp", {gpc_pkg::RESP_SLVERR, 30'h0}, {rs, rv[29:0]});
    final_report;
  end
endmodule : tb_top
